// [usart_consts.svh]
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// Register byte offsets on the AXI4-Lite bus
`define UTX_OFF_DATA 8'h00
`define UTX_OFF_STAT 8'h04
`define UTX_OFF_CTRL 8'h08
`define UTX_OFF_FMT 8'h0C
`define UTX_OFF_BAUD 8'h10

// status_reg_a fields
`define UTX_ST_RXRDY 7
`define UTX_ST_TXDONE 6
`define UTX_ST_TXEMPTY 5
`define UTX_ST_FERR 4
`define UTX_ST_OVR 3
`define UTX_ST_PERR 2

// control_reg_b fields
`define UTX_CB_RXIE 7
`define UTX_CB_TXDIE 6
`define UTX_CB_TXEIE 5
`define UTX_CB_RXEN 4
`define UTX_CB_TX_ENABLE_BIT 3
`define UTX_CB_RX9 1
`define UTX_CB_TX9 0
`define UTX_CB_GIE 8
`define UTX_CB_SYNC 9

// Format register fields
`define UTX_FM_PEN 5
`define UTX_FM_PODD 4
`define UTX_FM_STOP2 3
`define UTX_FM_CSZ_HI 2

// Reset values and sizes
`define UTX_RST_BAUD 16'h0363
`define UTX_RST_FMT 6'h06
`define UTX_CSZ_NINE 3'h7
`define UTX_FIFO_DEPTH 2
`define UTX_FIFO_AW 1
`define UTX_ENTRY_W 12

`endif

// [usart_pkg.sv]
package usart_pkg;
    // Transmit state machine, Gray along start-data-parity-stop
    typedef enum logic [2:0] {
        USART_TX_IDLE = 3'b000,
        USART_TX_START = 3'b001,
        USART_TX_DATA = 3'b011,
        USART_TX_PAR = 3'b010,
        USART_TX_STOP = 3'b110
    } usart_tx_state_e;

    // Receive state machine
    typedef enum logic [2:0] {
        USART_RX_IDLE = 3'b000,
        USART_RX_START = 3'b001,
        USART_RX_DATA = 3'b011,
        USART_RX_PAR = 3'b010,
        USART_RX_STOP = 3'b110
    } usart_rx_state_e;
endpackage : usart_pkg

// [usart_rx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

module usart_rx_fifo (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic flush, // Empties the buffer
    input wire logic wr_en, // Push one frame entry
    input wire logic [`UTX_ENTRY_W-1:0] wr_data, // Frame with status
    input wire logic rd_en, // Pop the head entry
    output logic [`UTX_ENTRY_W-1:0] rd_data, // Head entry, registered
    output logic empty, // No unread entry
    output logic full // All entries used
);
    logic [`UTX_ENTRY_W-1:0] mem_reg [`UTX_FIFO_DEPTH];
    logic [`UTX_FIFO_AW:0] wp_reg;
    logic [`UTX_FIFO_AW:0] rp_reg;
    logic [`UTX_FIFO_AW:0] rp_next;

    assign empty = (wp_reg == rp_reg);
    assign full = (wp_reg[`UTX_FIFO_AW] != rp_reg[`UTX_FIFO_AW]) &&
                  (wp_reg[`UTX_FIFO_AW-1:0] == rp_reg[`UTX_FIFO_AW-1:0]);
    assign rp_next = rp_reg + ((rd_en && !empty) ? 2'd1 : 2'd0);

    // Pointers; flush wins since the receiver is off anyway
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (flush) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            if (wr_en && !full) wp_reg <= wp_reg + 2'd1;
            rp_reg <= rp_next;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (wr_en && !full && !flush) mem_reg[wp_reg[`UTX_FIFO_AW-1:0]] <= wr_data;
    end

    // Head entry out of a register, follows pushes into an empty buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (wr_en && !full && (wp_reg[`UTX_FIFO_AW-1:0] == rp_next[`UTX_FIFO_AW-1:0])
                     && (wp_reg == rp_next)) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem_reg[rp_next[`UTX_FIFO_AW-1:0]];
        end
    end
endmodule : usart_rx_fifo
`default_nettype wire

// [usart_txrx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

module usart_txrx (
    input wire logic clk, // 100 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic tx_done_irq_ack, // CPU vectored to transmit-complete
    input wire logic serial_in_pin, // Serial receive line
    input wire logic sync_clock_pin, // External bit clock, sync mode
    output logic serial_out_pin, // Serial transmit line
    output logic serial_out_oe, // High while the transmitter owns the pin
    output logic serial_in_claim, // High while the receiver owns the pin
    output logic tx_empty_irq, // Transmit-buffer-empty request, level
    output logic tx_done_irq, // Transmit-complete request, level
    output logic rx_ready_irq // Receive-complete request, level
);
    // Control and format registers
    logic [9:0] ctrl_reg;
    logic [5:0] fmt_reg;
    logic [15:0] baud_reg;
    logic [8:0] txbuf_reg;
    logic txbuf_full_reg;
    logic tx_done_reg;
    // Bus handshake state
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_wr, do_rd;
    // Bit clock
    logic [15:0] bcnt_reg;
    logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
    logic bit_tick;
    // Transmitter
    usart_pkg::usart_tx_state_e tx_st_reg;
    logic [8:0] tsh_reg;
    logic [3:0] tcnt_reg;
    logic tpar_reg;
    logic tstop2_reg;
    logic tx_load, tx_finish;
    // Receiver
    usart_pkg::usart_rx_state_e rx_st_reg;
    logic [8:0] rsh_reg;
    logic [3:0] rcnt_reg;
    logic rpar_reg;
    logic ovr_reg;
    logic rx_push;
    logic [`UTX_ENTRY_W-1:0] rx_entry, head;
    logic fifo_empty, fifo_full;
    logic [3:0] nbits;
    logic [8:0] dmask;

    // Character size 5..8 by field, 9 when field is seven
    assign nbits = (fmt_reg[`UTX_FM_CSZ_HI:0] == `UTX_CSZ_NINE) ? 4'd9 :
                   (4'd5 + {1'b0, fmt_reg[`UTX_FM_CSZ_HI:0]});
    assign dmask = (9'h1FF >> (4'd9 - nbits));

    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
    assign do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read: one cycle after address, unmapped reads zero
    assign s_axi_arready = !s_axi_rvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;
    assign s_axi_rresp = 2'b00;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `UTX_OFF_DATA: s_axi_rdata <= {24'h000000, head[7:0] & dmask[7:0]};
                `UTX_OFF_STAT: s_axi_rdata <= {24'h000000, !fifo_empty, tx_done_reg,
                    !txbuf_full_reg, head[10], head[11], head[9], 2'b00};
                `UTX_OFF_CTRL: s_axi_rdata <= {22'h000000, ctrl_reg[9:2],
                    head[8] & (nbits == 4'd9), ctrl_reg[0]};
                `UTX_OFF_FMT: s_axi_rdata <= {26'h0000000, fmt_reg};
                `UTX_OFF_BAUD: s_axi_rdata <= {16'h0000, baud_reg};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control, format and baud registers; the received-ninth-bit position ignores writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= 10'h000;
            fmt_reg <= `UTX_RST_FMT;
            baud_reg <= `UTX_RST_BAUD;
        end else if (do_wr) begin
            if (aw_addr_reg == `UTX_OFF_CTRL && w_strb_reg[0]) ctrl_reg[7:0] <= w_data_reg[7:0];
            if (aw_addr_reg == `UTX_OFF_CTRL && w_strb_reg[1]) ctrl_reg[9:8] <= w_data_reg[9:8];
            if (aw_addr_reg == `UTX_OFF_FMT && w_strb_reg[0]) fmt_reg <= w_data_reg[5:0];
            if (aw_addr_reg == `UTX_OFF_BAUD && w_strb_reg[0]) baud_reg[7:0] <= w_data_reg[7:0];
            if (aw_addr_reg == `UTX_OFF_BAUD && w_strb_reg[1]) baud_reg[15:8] <= w_data_reg[15:8];
        end
    end

    // Bit clock: divider, or rising edge of sync pin (third flop only for edge)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_reg <= 16'h0000;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
        end else begin
            sck_s1_reg <= sync_clock_pin;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            bcnt_reg <= (bcnt_reg >= baud_reg) ? 16'h0000 : bcnt_reg + 16'h0001;
        end
    end
    assign bit_tick = ctrl_reg[`UTX_CB_SYNC] ? (sck_s2_reg && !sck_s3_reg)
                                             : (bcnt_reg >= baud_reg);

    // Transmit buffer: write fills, shifter load empties
    assign tx_load = txbuf_full_reg && bit_tick &&
                     (tx_st_reg == usart_pkg::USART_TX_IDLE || tx_finish);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txbuf_full_reg <= 1'b0;
            txbuf_reg <= 9'h000;
        end else if (do_wr && aw_addr_reg == `UTX_OFF_DATA && w_strb_reg[0] &&
                     ctrl_reg[`UTX_CB_TX_ENABLE_BIT]) begin
            txbuf_full_reg <= 1'b1;
            txbuf_reg <= {ctrl_reg[`UTX_CB_TX9], w_data_reg[7:0]};
        end else if (tx_load) begin
            txbuf_full_reg <= 1'b0;
        end
    end

    // Transmit shifter: start low, data LSB first, parity, stops
    assign tx_finish = (tx_st_reg == usart_pkg::USART_TX_STOP) && bit_tick && !tstop2_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_reg <= usart_pkg::USART_TX_IDLE;
            tsh_reg <= 9'h000;
            tcnt_reg <= 4'h0;
            tpar_reg <= 1'b0;
            tstop2_reg <= 1'b0;
        end else if (tx_load) begin
            tx_st_reg <= usart_pkg::USART_TX_START;
            tsh_reg <= txbuf_reg & dmask;
            tpar_reg <= (^(txbuf_reg & dmask)) ^ fmt_reg[`UTX_FM_PODD];
            tcnt_reg <= 4'h0;
        end else if (bit_tick) begin
            case (tx_st_reg)
                usart_pkg::USART_TX_START: tx_st_reg <= usart_pkg::USART_TX_DATA;
                usart_pkg::USART_TX_DATA: begin
                    tsh_reg <= tsh_reg >> 1;
                    tcnt_reg <= tcnt_reg + 4'h1;
                    if (tcnt_reg == nbits - 4'd1) begin
                        tx_st_reg <= fmt_reg[`UTX_FM_PEN] ? usart_pkg::USART_TX_PAR
                                                          : usart_pkg::USART_TX_STOP;
                        tstop2_reg <= fmt_reg[`UTX_FM_STOP2];
                    end
                end
                usart_pkg::USART_TX_PAR: tx_st_reg <= usart_pkg::USART_TX_STOP;
                usart_pkg::USART_TX_STOP: begin
                    if (tstop2_reg) tstop2_reg <= 1'b0;
                    else tx_st_reg <= usart_pkg::USART_TX_IDLE;
                end
                default: tx_st_reg <= usart_pkg::USART_TX_IDLE;
            endcase
        end
    end

    // Line level per state; pin released only when both stages drained
    always_comb begin
        case (tx_st_reg)
            usart_pkg::USART_TX_START: serial_out_pin = 1'b0;
            usart_pkg::USART_TX_DATA: serial_out_pin = tsh_reg[0];
            usart_pkg::USART_TX_PAR: serial_out_pin = tpar_reg;
            default: serial_out_pin = 1'b1;
        endcase
    end
    assign serial_out_oe = ctrl_reg[`UTX_CB_TX_ENABLE_BIT] || txbuf_full_reg ||
                           (tx_st_reg != usart_pkg::USART_TX_IDLE);

    // Done flag: set on last stop with empty buffer, set beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_done_reg <= 1'b0;
        end else if (tx_finish && !txbuf_full_reg) begin
            tx_done_reg <= 1'b1;
        end else if (tx_done_irq_ack || (do_wr && aw_addr_reg == `UTX_OFF_STAT &&
                     w_strb_reg[0] && w_data_reg[`UTX_ST_TXDONE])) begin
            tx_done_reg <= 1'b0;
        end
    end

    // Receiver: start, data, optional parity, first stop only
    assign serial_in_claim = ctrl_reg[`UTX_CB_RXEN];
    assign rx_push = (rx_st_reg == usart_pkg::USART_RX_STOP) && bit_tick;
    assign rx_entry = {ovr_reg, !serial_in_pin,
                       fmt_reg[`UTX_FM_PEN] && (rpar_reg != ((^(rsh_reg & dmask)) ^
                       fmt_reg[`UTX_FM_PODD])), rsh_reg & dmask};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_reg <= usart_pkg::USART_RX_IDLE;
            rsh_reg <= 9'h000;
            rcnt_reg <= 4'h0;
            rpar_reg <= 1'b0;
        end else if (!ctrl_reg[`UTX_CB_RXEN]) begin
            rx_st_reg <= usart_pkg::USART_RX_IDLE;
        end else if (bit_tick) begin
            case (rx_st_reg)
                usart_pkg::USART_RX_IDLE: if (!serial_in_pin) begin
                    rx_st_reg <= usart_pkg::USART_RX_DATA;
                    rcnt_reg <= 4'h0;
                    rsh_reg <= 9'h000;
                end
                usart_pkg::USART_RX_DATA: begin
                    rsh_reg[rcnt_reg] <= serial_in_pin;
                    rcnt_reg <= rcnt_reg + 4'h1;
                    if (rcnt_reg == nbits - 4'd1)
                        rx_st_reg <= fmt_reg[`UTX_FM_PEN] ? usart_pkg::USART_RX_PAR
                                                          : usart_pkg::USART_RX_STOP;
                end
                usart_pkg::USART_RX_PAR: begin
                    rpar_reg <= serial_in_pin;
                    rx_st_reg <= usart_pkg::USART_RX_STOP;
                end
                usart_pkg::USART_RX_STOP: rx_st_reg <= usart_pkg::USART_RX_IDLE;
                default: rx_st_reg <= usart_pkg::USART_RX_IDLE;
            endcase
        end
    end

    // Overrun: frame dropped with full buffer, cleared by a stored frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ovr_reg <= 1'b0;
        else if (!ctrl_reg[`UTX_CB_RXEN]) ovr_reg <= 1'b0;
        else if (rx_push && fifo_full) ovr_reg <= 1'b1;
        else if (rx_push) ovr_reg <= 1'b0;
    end

    // Two-entry FIFO; a data read pops data, ninth bit and status together
    usart_rx_fifo u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(!ctrl_reg[`UTX_CB_RXEN]),
        .wr_en(rx_push),
        .wr_data(rx_entry),
        .rd_en(do_rd && s_axi_araddr == `UTX_OFF_DATA),
        .rd_data(head),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // Level interrupt requests behind the global enable
    assign tx_empty_irq = ctrl_reg[`UTX_CB_GIE] && ctrl_reg[`UTX_CB_TXEIE] && !txbuf_full_reg;
    assign tx_done_irq = ctrl_reg[`UTX_CB_GIE] && ctrl_reg[`UTX_CB_TXDIE] && tx_done_reg;
    assign rx_ready_irq = ctrl_reg[`UTX_CB_GIE] && ctrl_reg[`UTX_CB_RXIE] && !fifo_empty;
endmodule : usart_txrx
`default_nettype wire

// [usart_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

module usart_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic tx_done_irq_ack, // Done serviced
    input wire logic serial_out_pin, // TX line
    input wire logic serial_out_oe, // TX owns pin
    input wire logic serial_in_claim, // RX owns pin
    input wire logic tx_empty_irq, // Empty request
    input wire logic tx_done_irq, // Done request
    input wire logic rx_ready_irq // Ready request
);
    logic [7:0] a_sh;
    logic [31:0] d_sh;
    logic [9:0] c_sh;
    logic [15:0] b_sh;
    logic wip;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Shadows follow the response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_sh <= 8'h00;
            d_sh <= 32'h00000000;
            c_sh <= 10'h000;
            b_sh <= `UTX_RST_BAUD;
            wip <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) a_sh <= s_axi_awaddr;
            if (s_axi_awvalid && s_axi_awready) wip <= 1'b1;
            if (s_axi_wvalid && s_axi_wready) d_sh <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready) wip <= 1'b0;
            if (s_axi_bvalid && s_axi_bready && a_sh == `UTX_OFF_CTRL) c_sh <= d_sh[9:0];
            if (s_axi_bvalid && s_axi_bready && a_sh == `UTX_OFF_BAUD) b_sh <= d_sh[15:0];
        end
    end

    claim_follows_a: assert property (!wip |-> serial_in_claim == c_sh[`UTX_CB_RXEN])
        else $error("claim wrong");
    empty_gate_a: assert property (!wip && !(c_sh[`UTX_CB_GIE] && c_sh[`UTX_CB_TXEIE])
        |-> !tx_empty_irq)
        else $error("empty masked");
    done_gate_a: assert property (!wip && !(c_sh[`UTX_CB_GIE] && c_sh[`UTX_CB_TXDIE])
        |-> !tx_done_irq)
        else $error("done masked");
    ready_gate_a: assert property (!wip && !(c_sh[`UTX_CB_GIE] && c_sh[`UTX_CB_RXIE])
        |-> !rx_ready_irq)
        else $error("ready masked");
    flush_clear_a: assert property (!wip && !c_sh[`UTX_CB_RXEN] |-> !rx_ready_irq)
        else $error("ready while off");
    ack_clear_a: assert property (tx_done_irq && tx_done_irq_ack |=> !tx_done_irq)
        else $error("ack ignored");
    idle_high_a: assert property (!serial_out_oe |-> serial_out_pin)
        else $error("idle low");
    release_a: assert property ($fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin))
        else $error("early release");
    bit_len_a: assert property ($fell(serial_out_pin) && serial_out_oe && b_sh == 16'h0007
        |-> !serial_out_pin [*8])
        else $error("short low bit");
    done_stop_a: assert property ($rose(tx_done_irq) && !wip && !$past(wip) |-> serial_out_pin)
        else $error("early done");
endmodule : usart_chk
`default_nettype wire

// [usart_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module usart_peer #(
    parameter int BT = 8 // Bit period, cycles
) (
    input wire logic clk, // System clock
    input wire logic tx_line, // Line from the block
    output logic rx_line // Line into the block
);
    logic [9:0] frm_q[$];
    int tm_q[$];
    int now = 0;
    logic [9:0] f;
    int t;

    // Cycles for spacing
    always @(posedge clk) now <= now + 1;

    // Sample each bit mid-period
    initial begin
        rx_line = 1'b1; // Idle high
        forever begin
            @(negedge tx_line);
            t = now;
            repeat (BT / 2) @(negedge clk);
            for (int i = 0; i < 10; i++) begin
                repeat (BT) @(negedge clk);
                f[i] = tx_line; // LSB first
            end
            frm_q.push_back(f);
            tm_q.push_back(t);
        end
    end

    // One frame out, then an idle bit
    task automatic send(input logic [8:0] d, input int n, input logic pen, input int ns);
        logic p = 1'b0;
        @(posedge clk);
        rx_line <= 1'b0; // Low start
        repeat (BT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_line <= d[i]; // LSB first
            p = p ^ d[i]; // Even parity
            repeat (BT) @(posedge clk);
        end
        if (pen) begin
            rx_line <= p; // Parity before stop
            repeat (BT) @(posedge clk);
        end
        rx_line <= 1'b1; // High stops
        repeat ((ns + 1) * BT) @(posedge clk);
    endtask : send
endmodule : usart_peer
`default_nettype wire

// [test_usart_txrx.sv]
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

bind usart_txrx usart_chk u_chk (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .tx_done_irq_ack,
    .serial_out_pin, .serial_out_oe, .serial_in_claim, .tx_empty_irq, .tx_done_irq, .rx_ready_irq);

module test_usart_txrx;
    logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic tx_done_irq_ack, serial_in_pin, serial_out_pin, serial_out_oe, serial_in_claim;
    logic tx_empty_irq, tx_done_irq, rx_ready_irq;
    int err_total, check_count;

    usart_txrx DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tx_done_irq_ack, .serial_in_pin, .sync_clock_pin(1'b0), .serial_out_pin,
        .serial_out_oe, .serial_in_claim, .tx_empty_irq, .tx_done_irq, .rx_ready_irq);
    usart_peer #(.BT(8)) peer (.clk, .tx_line(serial_out_oe ? serial_out_pin : 1'b1),
        .rx_line(serial_in_pin));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One bus cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic ok = 1'b0;
        v = 'x;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!ok && n < 50) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) begin
                ok = 1'b1;
                v = s_axi_rdata;
                rr = w ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        chk("bus answer", 1, ok);
    endtask : bus

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, v);
    endtask : rdc

    // Bounded wait
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 400 && s !== 1'b1; n++) @(posedge clk);
    endtask : wait_hi

    task automatic wait_q(input int k);
        for (int n = 0; n < 3000 && peer.frm_q.size() < k; n++) @(posedge clk);
        chk("frame count", k, peer.frm_q.size());
    endtask : wait_q

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Ample margin over the run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        {err_total, check_count} = 0;
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_done_irq_ack} = 0;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc("status", `UTX_OFF_STAT, 32'h00000020);
        rdc("format", `UTX_OFF_FMT, 32'h00000006);
        rdc("baud", `UTX_OFF_BAUD, 32'h00000363);
        rdc("control", `UTX_OFF_CTRL, 32'h00000000);
        rdc("unmapped", 8'h14, 32'h00000000);
        chk("unmapped resp", 2'h0, rr);
        chk("oe idle", 0, serial_out_oe);
        $display("test reset done");
        bus(1'b1, `UTX_OFF_BAUD, 32'h00000007);
        bus(1'b1, `UTX_OFF_FMT, 32'h00000023);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000168);
        chk("empty irq", 1, tx_empty_irq);
        bus(1'b1, `UTX_OFF_DATA, 32'h000000A5);
        wait_hi(tx_empty_irq);
        bus(1'b1, `UTX_OFF_DATA, 32'h0000003D);
        rdc("status full", `UTX_OFF_STAT, 32'h00000000);
        chk("empty irq full", 0, tx_empty_irq);
        wait_q(2);
        chk("frame a5", {2'b10, 8'hA5}, peer.frm_q[0]);
        chk("frame 3d", {2'b11, 8'h3D}, peer.frm_q[1]);
        chk("gap", 88, peer.tm_q[1] - peer.tm_q[0]);
        wait_hi(tx_done_irq);
        rdc("status done", `UTX_OFF_STAT, 32'h00000060);
        tx_done_irq_ack <= 1'b1;
        @(posedge clk);
        tx_done_irq_ack <= 1'b0;
        rdc("status ack", `UTX_OFF_STAT, 32'h00000020);
        bus(1'b1, `UTX_OFF_FMT, 32'h00000037);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000169);
        bus(1'b1, `UTX_OFF_DATA, 32'h0000000F);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000160);
        chk("oe kept", 1, serial_out_oe);
        wait_q(3);
        chk("frame odd", 10'h10F, peer.frm_q[2]);
        wait_hi(tx_done_irq);
        rdc("status end", `UTX_OFF_STAT, 32'h00000060);
        chk("oe off", 0, serial_out_oe);
        bus(1'b1, `UTX_OFF_STAT, 32'h00000000);
        rdc("write zero", `UTX_OFF_STAT, 32'h00000060);
        bus(1'b1, `UTX_OFF_STAT, 32'h00000040);
        rdc("write one", `UTX_OFF_STAT, 32'h00000020);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000000);
        chk("empty masked", 0, tx_empty_irq);
        $display("test tx done");
        bus(1'b1, `UTX_OFF_FMT, 32'h0000002F);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000190);
        chk("claim on", 1, serial_in_claim);
        peer.send(9'h1A5, 9, 1'b1, 2);
        peer.send(9'h0C3, 9, 1'b1, 2);
        chk("ready irq", 1, rx_ready_irq);
        rdc("status two", `UTX_OFF_STAT, 32'h000000A0);
        rdc("ninth a", `UTX_OFF_CTRL, 32'h00000192);
        bus(1'b0, `UTX_OFF_DATA, 32'h00000000);
        chk("data a", 8'hA5, v[7:0]);
        rdc("ninth b", `UTX_OFF_CTRL, 32'h00000190);
        bus(1'b0, `UTX_OFF_DATA, 32'h00000000);
        chk("data b", 8'hC3, v[7:0]);
        rdc("status empty", `UTX_OFF_STAT, 32'h00000020);
        chk("ready irq off", 0, rx_ready_irq);
        bus(1'b1, `UTX_OFF_FMT, 32'h00000001);
        peer.send(9'h02A, 6, 1'b0, 1);
        peer.send(9'h015, 6, 1'b0, 1);
        rdc("six bit", `UTX_OFF_DATA, 32'h0000002A);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000180);
        chk("claim off", 0, serial_in_claim);
        bus(1'b1, `UTX_OFF_CTRL, 32'h00000190);
        rdc("flushed", `UTX_OFF_STAT, 32'h00000020);
        $display("test rx done");
        test_done();
    end
endmodule : test_usart_txrx
`default_nettype wire
